// *** hdl/psrc_pkg.sv ***
package psrc_pkg;

  // ---------------------------------------------------------------
  // Register map (data-space offsets)
  // ---------------------------------------------------------------
  localparam logic [7:0] PSRC_SLEEP_CONTROL_OFS = 8'h53;
  localparam logic [7:0] PSRC_MCU_CONTROL_OFS = 8'h55;
  localparam logic [7:0] PSRC_POWER_REDUCTION_OFS = 8'h64;
  localparam logic [7:0] PSRC_IO_SPACE_BASE = 8'h20;
  localparam logic [7:0] PSRC_IO_SPACE_LAST = 8'h3f;

  // ---------------------------------------------------------------
  // Reset values and writable masks
  // ---------------------------------------------------------------
  localparam logic [7:0] PSRC_SLEEP_CONTROL_RST = 8'h00;
  localparam logic [7:0] PSRC_MCU_CONTROL_RST = 8'h00;
  localparam logic [7:0] PSRC_POWER_REDUCTION_RST = 8'h00;
  localparam logic [7:0] PSRC_SLEEP_CONTROL_MASK = 8'h0f;
  localparam logic [7:0] PSRC_MCU_CONTROL_MASK = 8'h73;
  localparam logic [7:0] PSRC_POWER_REDUCTION_MASK = 8'hef;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int PSRC_SE_BIT = 0;
  localparam int PSRC_SM_LO = 1;
  localparam int PSRC_SM_HI = 3;
  localparam int PSRC_VECTOR_CHANGE_ENABLE_BIT = 0;
  localparam int PSRC_VECTOR_TABLE_SELECT_BIT = 1;
  localparam int PSRC_PUD_BIT = 4;
  localparam int PSRC_BROWNOUT_SLEEP_CHANGE_ENABLE_BIT = 5;
  localparam int PSRC_BROWNOUT_SLEEP_DISABLE_BIT = 6;
  localparam int PSRC_GATE_CONV_BIT = 0;
  localparam int PSRC_GATE_TIMER2_BIT = 6;

  // ---------------------------------------------------------------
  // Timing counts in clock cycles
  // ---------------------------------------------------------------
  localparam logic [2:0] PSRC_WINDOW_CYCLES = 3'd4;
  localparam logic [2:0] PSRC_BROWNOUT_SLEEP_DISABLE_DELAY_CYCLES = 3'd3;
  localparam logic [2:0] PSRC_BROWNOUT_SLEEP_DISABLE_ACTIVE_CYCLES = 3'd3;

  // ---------------------------------------------------------------
  // Sleep modes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    PSRC_SM_IDLE = 3'b000,
    PSRC_SM_NOISE = 3'b001,
    PSRC_SM_PDOWN = 3'b010,
    PSRC_SM_PSAVE = 3'b011,
    PSRC_SM_RSVD4 = 3'b100,
    PSRC_SM_RSVD5 = 3'b101,
    PSRC_SM_STBY = 3'b110,
    PSRC_SM_XSTBY = 3'b111
  } psrc_sleep_mode_t;

  // CPU register access bundle
  typedef struct packed {
    logic rd;
    logic wr;
    logic io_space;
    logic [7:0] addr;
    logic [7:0] wdata;
  } psrc_cpu_req_t;

  // Sleep request result to the clock controller
  typedef struct packed {
    logic enter;
    logic [2:0] mode;
    logic bod_off;
  } psrc_sleep_cmd_t;

endpackage : psrc_pkg

// *** hdl/psrc_power_sleep_reset_control.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - Sleep only when sleep enable bit set
// - Mode field selects six modes, two reserved
// - Brown-out disable needs two-write timed sequence
// - Disable active after three, clears after three
// - Detector off only if sleep during active
// - Global pull-up disable overrides all pull-ups
// - Vector select picks flash start or boot
// - Vector change needs enable then select write
// - Interrupts blocked during vector change sequence
// - Change enable self-clears after four cycles
// - Boot locks block interrupts by code section
// - Power-reduction bits stop peripheral clocks
// - Timer 2 gated only when clocked synchronously
// - Gated timer resumes from its held state
// - Converter gated blocks comparator mux use
// - I/O-space address is data offset minus 0x20
// - Reset returns registers to initial values
// - Ports reset at once without clock
// - Delay counter stretches reset after sources release
// - Four reset sources: power, pin, watchdog, brown-out
// - Watchdog pulse one cycle; delay starts after
module psrc_power_sleep_reset_control #(
  parameter int TIMEOUT_W = 16
) (
  // Clock and raw asynchronous reset sources
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic power_on_rst_i,
  input wire logic ext_rst_pin_n_i,
  input wire logic brownout_rst_i,
  input wire logic watchdog_rst_pulse_i,
  // Fuse and lock settings
  input wire logic [TIMEOUT_W-1:0] timeout_cycles_i,
  input wire logic app_side_boot_lock_i,
  input wire logic boot_side_boot_lock_i,
  input wire logic timer2_async_select_i,
  // CPU side
  input wire psrc_pkg::psrc_cpu_req_t cpu_req_i,
  input wire logic sleep_instr_i,
  input wire logic exec_in_boot_i,
  output logic [7:0] cpu_rdata_o,
  output logic cpu_hit_o,
  output logic irq_block_o,
  output logic vectors_in_boot_o,
  output logic core_rst_o,
  output logic port_rst_o,
  // Sleep and power control
  output psrc_pkg::psrc_sleep_cmd_t sleep_cmd_o,
  output logic global_pullup_disable_o,
  output logic [7:0] clock_gate_o,
  output logic comparator_mux_block_o
);
  import psrc_pkg::*;

  // ---------------------------------------------------------------
  // Reset sources
  // ---------------------------------------------------------------
  // Any source forces ports and the stretch counter at once
  // rst_i joins the hardware sources so a bench or system reset
  // takes the same clockless path as the pins and detectors
  wire any_src_w = rst_i | power_on_rst_i | ~ext_rst_pin_n_i | brownout_rst_i | watchdog_rst_pulse_i;
  logic [1:0] src_sync_r; // Release synchroniser
  logic [TIMEOUT_W-1:0] stretch_r; // Delay counter
  logic core_rst_r;

  // Release is synchronised so stretch starts cleanly on clock
  always_ff @(posedge clock_i or posedge any_src_w) begin
    if (any_src_w) begin
      src_sync_r <= 2'b11;
    end else begin
      src_sync_r <= {src_sync_r[0], 1'b0};
    end
  end

  // Count starts after the watchdog pulse falls, as for all sources
  // The counter only runs once the synchroniser has drained, so a
  // source that bounces restarts the whole stretch from zero.
  // Limitation: the stretch length is sampled live, so the fuse
  // value must not change while the counter runs.
  always_ff @(posedge clock_i or posedge any_src_w) begin
    if (any_src_w) begin
      stretch_r <= '0;
      core_rst_r <= 1'b1;
    end else if (src_sync_r[1]) begin
      stretch_r <= '0;
      core_rst_r <= 1'b1;
    end else if (stretch_r < timeout_cycles_i) begin
      stretch_r <= stretch_r + 1'b1;
      core_rst_r <= 1'b1;
    end else begin
      core_rst_r <= 1'b0;
    end
  end
  assign core_rst_o = core_rst_r;
  // Ports follow the raw sources with no clock needed
  // This is the one output that is not registered: ports must let
  // go of their drivers even when no clock is running
  assign port_rst_o = any_src_w;

  // Internal register reset is the stretched reset
  wire reg_rst_w = core_rst_r;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  // I/O-space requests carry the short address; adding the base
  // gives the data-space offset, so one compare serves both views.
  // Offsets above the I/O window have no short alias and miss.
  wire [7:0] io_addr_w = cpu_req_i.addr + PSRC_IO_SPACE_BASE;
  wire io_ok_w = cpu_req_i.addr <= PSRC_IO_SPACE_LAST;
  wire [7:0] eff_addr_w = cpu_req_i.io_space ? io_addr_w : cpu_req_i.addr;
  wire addr_ok_w = ~cpu_req_i.io_space | io_ok_w;
  wire sel_smc_w = addr_ok_w & (eff_addr_w == PSRC_SLEEP_CONTROL_OFS);
  wire sel_mcu_w = addr_ok_w & (eff_addr_w == PSRC_MCU_CONTROL_OFS);
  wire sel_prr_w = addr_ok_w & (eff_addr_w == PSRC_POWER_REDUCTION_OFS);
  wire wr_smc_w = cpu_req_i.wr & sel_smc_w;
  wire wr_mcu_w = cpu_req_i.wr & sel_mcu_w;
  wire wr_prr_w = cpu_req_i.wr & sel_prr_w;
  wire [7:0] wd_w = cpu_req_i.wdata;

  // ---------------------------------------------------------------
  // Sleep control and power reduction
  // ---------------------------------------------------------------
  logic [7:0] sleep_control_r;
  logic [7:0] power_reduction_r;

  // Stored bits masked so unused positions stay zero
  // Both registers take a whole byte per write; there is no
  // partial update, so software reads, modifies and writes back
  always_ff @(posedge clock_i or posedge reg_rst_w) begin
    if (reg_rst_w) begin
      sleep_control_r <= PSRC_SLEEP_CONTROL_RST;
      power_reduction_r <= PSRC_POWER_REDUCTION_RST;
    end else begin
      if (wr_smc_w) sleep_control_r <= wd_w & PSRC_SLEEP_CONTROL_MASK;
      if (wr_prr_w) power_reduction_r <= wd_w & PSRC_POWER_REDUCTION_MASK;
    end
  end

  // ---------------------------------------------------------------
  // Brown-out sleep disable timed sequence
  // ---------------------------------------------------------------
  logic brownout_sleep_change_enable_r; // Change enable, open for four cycles
  logic [2:0] brownout_sleep_change_enable_cnt_r;
  logic brownout_sleep_disable_pend_r; // Written, not yet active
  logic brownout_sleep_disable_act_r; // Active, detector may be switched off
  logic [2:0] brownout_sleep_disable_cnt_r;
  wire brownout_sleep_disable_arm_w = wr_mcu_w & wd_w[PSRC_BROWNOUT_SLEEP_DISABLE_BIT] & wd_w[PSRC_BROWNOUT_SLEEP_CHANGE_ENABLE_BIT];
  wire brownout_sleep_disable_set_w = wr_mcu_w & brownout_sleep_change_enable_r & wd_w[PSRC_BROWNOUT_SLEEP_DISABLE_BIT] & ~wd_w[PSRC_BROWNOUT_SLEEP_CHANGE_ENABLE_BIT];

  // Second write only counts inside the change window
  // The arm write opens a four-cycle window; the set write must
  // clear the change enable in the same byte or it is ignored.
  // Pending then active each last three cycles, and a fresh set
  // write restarts the pending phase rather than extending it.
  always_ff @(posedge clock_i or posedge reg_rst_w) begin
    if (reg_rst_w) begin
      brownout_sleep_change_enable_r <= 1'b0;
      brownout_sleep_change_enable_cnt_r <= 3'd0;
      brownout_sleep_disable_pend_r <= 1'b0;
      brownout_sleep_disable_act_r <= 1'b0;
      brownout_sleep_disable_cnt_r <= 3'd0;
    end else begin
      if (brownout_sleep_disable_arm_w) begin
        brownout_sleep_change_enable_r <= 1'b1;
        brownout_sleep_change_enable_cnt_r <= PSRC_WINDOW_CYCLES - 3'd1;
      end else if (brownout_sleep_disable_set_w || brownout_sleep_change_enable_cnt_r == 3'd0) begin
        brownout_sleep_change_enable_r <= 1'b0;
      end else begin
        brownout_sleep_change_enable_cnt_r <= brownout_sleep_change_enable_cnt_r - 3'd1;
      end
      if (brownout_sleep_disable_set_w) begin
        brownout_sleep_disable_pend_r <= 1'b1;
        brownout_sleep_disable_act_r <= 1'b0;
        brownout_sleep_disable_cnt_r <= PSRC_BROWNOUT_SLEEP_DISABLE_DELAY_CYCLES - 3'd1;
      end else if (brownout_sleep_disable_pend_r) begin
        if (brownout_sleep_disable_cnt_r == 3'd0) begin
          brownout_sleep_disable_pend_r <= 1'b0;
          brownout_sleep_disable_act_r <= 1'b1;
          brownout_sleep_disable_cnt_r <= PSRC_BROWNOUT_SLEEP_DISABLE_ACTIVE_CYCLES - 3'd1;
        end else begin
          brownout_sleep_disable_cnt_r <= brownout_sleep_disable_cnt_r - 3'd1;
        end
      end else if (brownout_sleep_disable_act_r) begin
        if (brownout_sleep_disable_cnt_r == 3'd0) begin
          brownout_sleep_disable_act_r <= 1'b0;
        end else begin
          brownout_sleep_disable_cnt_r <= brownout_sleep_disable_cnt_r - 3'd1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Vector select timed sequence
  // ---------------------------------------------------------------
  logic vector_change_enable_r;
  logic [2:0] vector_change_enable_cnt_r;
  logic vector_table_select_r;
  logic pud_r;
  logic post_sel_r; // Covers the instruction after the select write
  wire vector_change_enable_set_w = wr_mcu_w & wd_w[PSRC_VECTOR_CHANGE_ENABLE_BIT];
  wire vector_table_select_wr_w = wr_mcu_w & vector_change_enable_r & ~wd_w[PSRC_VECTOR_CHANGE_ENABLE_BIT];

  // Change enable dies after four cycles or on the select write
  // Pull-up disable shares the byte and follows every write, which
  // is why the select write must carry the pull-up bit it wants.
  // post_sel_r stretches the block over the next instruction.
  always_ff @(posedge clock_i or posedge reg_rst_w) begin
    if (reg_rst_w) begin
      vector_change_enable_r <= 1'b0;
      vector_change_enable_cnt_r <= 3'd0;
      vector_table_select_r <= 1'b0;
      pud_r <= 1'b0;
      post_sel_r <= 1'b0;
    end else begin
      if (wr_mcu_w) pud_r <= wd_w[PSRC_PUD_BIT];
      if (vector_table_select_wr_w) vector_table_select_r <= wd_w[PSRC_VECTOR_TABLE_SELECT_BIT];
      post_sel_r <= vector_table_select_wr_w;
      if (vector_change_enable_set_w) begin
        vector_change_enable_r <= 1'b1;
        vector_change_enable_cnt_r <= PSRC_WINDOW_CYCLES - 3'd1;
      end else if (vector_table_select_wr_w || vector_change_enable_cnt_r == 3'd0) begin
        vector_change_enable_r <= 1'b0;
      end else begin
        vector_change_enable_cnt_r <= vector_change_enable_cnt_r - 3'd1;
      end
    end
  end

  // Block from the enabling cycle; the core's I flag is untouched
  // Lock-driven blocking is a level, not a sequence: it holds for
  // as long as code runs from the protected side of the flash
  wire lock_block_w = (vector_table_select_r & app_side_boot_lock_i & ~exec_in_boot_i) |
                      (~vector_table_select_r & boot_side_boot_lock_i & exec_in_boot_i);
  wire irq_block_w = vector_change_enable_set_w | vector_change_enable_r | post_sel_r | lock_block_w;

  // ---------------------------------------------------------------
  // Sleep entry
  // ---------------------------------------------------------------
  // Reserved mode codes make the sleep instruction a no-op, the
  // same as a clear enable bit, so no half-defined state is entered
  wire [2:0] sm_w = sleep_control_r[PSRC_SM_HI:PSRC_SM_LO];
  wire sm_ok_w = (sm_w != PSRC_SM_RSVD4) && (sm_w != PSRC_SM_RSVD5);
  wire enter_w = sleep_instr_i & sleep_control_r[PSRC_SE_BIT] & sm_ok_w;
  wire bod_off_w = enter_w & brownout_sleep_disable_act_r;

  // ---------------------------------------------------------------
  // Clock gating
  // ---------------------------------------------------------------
  // Gating only stops clocks; the peripherals keep their state,
  // so clearing a bit resumes them where they stopped
  logic [7:0] gate_w;
  always_comb begin
    gate_w = power_reduction_r;
    // Asynchronous timer 2 keeps its own clock
    gate_w[PSRC_GATE_TIMER2_BIT] = power_reduction_r[PSRC_GATE_TIMER2_BIT] & ~timer2_async_select_i;
  end

  // ---------------------------------------------------------------
  // Read data and registered outputs
  // ---------------------------------------------------------------
  // Bit 6 shows only the active phase; pending reads as zero
  wire [7:0] mcu_rd_w = {1'b0, brownout_sleep_disable_act_r, brownout_sleep_change_enable_r, pud_r, 2'b00, vector_table_select_r, vector_change_enable_r};
  wire [7:0] rd_w = sel_smc_w ? sleep_control_r :
                    sel_mcu_w ? mcu_rd_w :
                    sel_prr_w ? power_reduction_r : 8'h00;
  // Reads of any other offset return zero and no hit
  wire hit_w = cpu_req_i.rd & (sel_smc_w | sel_mcu_w | sel_prr_w);

  // All outputs but port_rst_o registered; gates only stop the clock, state is kept
  // Each output is one flop behind the state it reflects, so a
  // write shows on the gates and pull-up output a cycle later
  always_ff @(posedge clock_i or posedge reg_rst_w) begin
    if (reg_rst_w) begin
      cpu_rdata_o <= 8'h00;
      cpu_hit_o <= 1'b0;
      irq_block_o <= 1'b0;
      vectors_in_boot_o <= 1'b0;
      sleep_cmd_o <= '0;
      global_pullup_disable_o <= 1'b0;
      clock_gate_o <= 8'h00;
      comparator_mux_block_o <= 1'b0;
    end else begin
      cpu_rdata_o <= cpu_req_i.rd ? rd_w : 8'h00;
      cpu_hit_o <= hit_w;
      irq_block_o <= irq_block_w;
      vectors_in_boot_o <= vector_table_select_r;
      sleep_cmd_o <= '{enter: enter_w, mode: sm_w, bod_off: bod_off_w};
      global_pullup_disable_o <= pud_r;
      clock_gate_o <= gate_w;
      comparator_mux_block_o <= power_reduction_r[PSRC_GATE_CONV_BIT];
    end
  end

endmodule : psrc_power_sleep_reset_control

// *** tb/psrc_power_sleep_reset_control_assertions.sv ***
`timescale 1ns/1ps
module psrc_power_sleep_reset_control_assertions
  import psrc_pkg::*;
#(
  parameter int TIMEOUT_W = 16
) (
  // Clock and sources
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic power_on_rst_i,
  input wire logic ext_rst_pin_n_i,
  input wire logic brownout_rst_i,
  input wire logic watchdog_rst_pulse_i,
  input wire logic timer2_async_select_i,
  // CPU side
  input wire psrc_pkg::psrc_cpu_req_t cpu_req_i,
  input wire logic sleep_instr_i,
  input wire logic [7:0] cpu_rdata_o,
  input wire logic cpu_hit_o,
  input wire logic irq_block_o,
  input wire logic core_rst_o,
  input wire logic port_rst_o,
  // Power control
  input wire psrc_pkg::psrc_sleep_cmd_t sleep_cmd_o,
  input wire logic global_pullup_disable_o,
  input wire logic [7:0] clock_gate_o,
  input wire logic comparator_mux_block_o
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  wire any_src = power_on_rst_i | ~ext_rst_pin_n_i | brownout_rst_i | watchdog_rst_pulse_i;
  // Data 0x53/0x55/0x64, I/O aliases 0x33/0x35 only
  wire mapped = cpu_req_i.io_space ? (cpu_req_i.addr == 8'h33 || cpu_req_i.addr == 8'h35) :
    (cpu_req_i.addr == 8'h53 || cpu_req_i.addr == 8'h55 || cpu_req_i.addr == 8'h64);
  default clocking cb @(posedge clock_i); endclocking
  // Port reset also follows rst_i, so rst_i masks every check while it is high
  default disable iff (rst_i);
  port_rst_follow_a: assert property (port_rst_o == any_src) else $error("port reset wrong");
  core_rst_hold_a: assert property (any_src |=> core_rst_o) else $error("core reset dropped");
  core_quiet_a: assert property (core_rst_o |-> clock_gate_o == 8'h00 && !irq_block_o
    && !global_pullup_disable_o && !sleep_cmd_o.enter) else $error("outputs live in reset");
  enter_cause_a: assert property (sleep_cmd_o.enter |-> $past(sleep_instr_i)
    && sleep_cmd_o.mode != 3'b100 && sleep_cmd_o.mode != 3'b101) else $error("bad sleep entry");
  unused_gate_a: assert property (clock_gate_o[4] == 1'b0) else $error("gate bit4 set");
  mux_block_a: assert property (comparator_mux_block_o == clock_gate_o[0]) else $error("mux block wrong");
  timer2_async_a: assert property (timer2_async_select_i && $past(timer2_async_select_i)
    |-> !clock_gate_o[6]) else $error("async timer gated");
  unmapped_rd_a: assert property (cpu_req_i.rd && !mapped |=> !cpu_hit_o && cpu_rdata_o == 8'h00)
    else $error("unmapped read hit");
  mapped_rd_a: assert property (cpu_req_i.rd && mapped && !core_rst_o |=> cpu_hit_o || core_rst_o)
    else $error("mapped read missed");
  rdata_idle_a: assert property (!$past(cpu_req_i.rd) |-> cpu_rdata_o == 8'h00) else $error("stray rdata");
endmodule : psrc_power_sleep_reset_control_assertions

bind psrc_power_sleep_reset_control psrc_power_sleep_reset_control_assertions #(.TIMEOUT_W(TIMEOUT_W))
  u_psrc_power_sleep_reset_control_assertions (.clock_i, .rst_i, .power_on_rst_i, .ext_rst_pin_n_i,
  .brownout_rst_i, .watchdog_rst_pulse_i, .timer2_async_select_i, .cpu_req_i, .sleep_instr_i, .cpu_rdata_o,
  .cpu_hit_o, .irq_block_o, .core_rst_o, .port_rst_o, .sleep_cmd_o, .global_pullup_disable_o, .clock_gate_o,
  .comparator_mux_block_o);

// *** tb/psrc_power_sleep_reset_control_tb.sv ***
`timescale 1ns/1ps
module psrc_power_sleep_reset_control_tb;
  import psrc_pkg::*;
  // ---------------------------------------------------------------
  // Stimulus and observation
  // ---------------------------------------------------------------
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic power_on_rst_i = 1'b0, ext_rst_pin_n_i = 1'b1, brownout_rst_i = 1'b0, watchdog_rst_pulse_i = 1'b0;
  logic [15:0] timeout_cycles_i = 16'h0004; // Short stretch keeps the run brief
  logic app_side_boot_lock_i = 1'b0, boot_side_boot_lock_i = 1'b0, timer2_async_select_i = 1'b0;
  psrc_cpu_req_t cpu_req_i = '0;
  logic sleep_instr_i = 1'b0, exec_in_boot_i = 1'b0;
  logic [7:0] cpu_rdata_o, clock_gate_o, rd_v;
  logic cpu_hit_o, irq_block_o, vectors_in_boot_o, core_rst_o, port_rst_o, hit_v, seen;
  logic global_pullup_disable_o, comparator_mux_block_o;
  psrc_sleep_cmd_t sleep_cmd_o;
  int bad_count = 0, num_checks = 0, n;
  always #2 clock_i = ~clock_i;
  psrc_power_sleep_reset_control u_psrc_power_sleep_reset_control (.clock_i, .rst_i, .power_on_rst_i,
    .ext_rst_pin_n_i, .brownout_rst_i, .watchdog_rst_pulse_i, .timeout_cycles_i, .app_side_boot_lock_i,
    .boot_side_boot_lock_i, .timer2_async_select_i, .cpu_req_i, .sleep_instr_i, .exec_in_boot_i, .cpu_rdata_o,
    .cpu_hit_o, .irq_block_o, .vectors_in_boot_o, .core_rst_o, .port_rst_o, .sleep_cmd_o,
    .global_pullup_disable_o, .clock_gate_o, .comparator_mux_block_o);
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  // One-cycle request; read data lands one edge later, sampled when released
  task automatic acc(input logic w, input logic io, input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_i);
    cpu_req_i = '{rd: !w, wr: w, io_space: io, addr: a, wdata: d};
    @(negedge clock_i);
    cpu_req_i = '0;
    rd_v = cpu_rdata_o;
    hit_v = cpu_hit_o;
  endtask : acc
  // Sleep pulse; the registered command is seen on release
  task automatic slp;
    @(negedge clock_i);
    sleep_instr_i = 1'b1;
    @(negedge clock_i);
    sleep_instr_i = 1'b0;
  endtask : slp
  // Bounded wait for the stretched reset to end
  task automatic wait_run;
    n = 0;
    while (core_rst_o !== 1'b0) begin
      @(negedge clock_i);
      n++;
      if (n > 60) begin
        bad_count++;
        close_out();
      end
    end
  endtask : wait_run
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(negedge clock_i);
    rst_i = 1'b0;
    wait_run();
    // Two synchroniser cycles plus the stretch of four plus one
    check(n[7:0], 8'h07);
    acc(0, 0, PSRC_SLEEP_CONTROL_OFS, 8'h00);
    check(rd_v, PSRC_SLEEP_CONTROL_RST);
    check({7'h0, hit_v}, 8'h01);
    acc(0, 0, PSRC_MCU_CONTROL_OFS, 8'h00);
    check(rd_v, PSRC_MCU_CONTROL_RST);
    // Unused bits drop on write; no debugger or live converter here
    acc(1, 0, PSRC_POWER_REDUCTION_OFS, 8'hff);
    acc(0, 0, PSRC_POWER_REDUCTION_OFS, 8'h00);
    check(rd_v, 8'hef);
    check(clock_gate_o, 8'hef);
    check({7'h0, comparator_mux_block_o}, 8'h01);
    timer2_async_select_i = 1'b1;
    repeat (2) @(negedge clock_i);
    check(clock_gate_o, 8'haf);
    timer2_async_select_i = 1'b0;
    // Clearing the bits releases every gate; gates lag one cycle
    acc(1, 0, PSRC_POWER_REDUCTION_OFS, 8'h00);
    @(negedge clock_i);
    check(clock_gate_o, 8'h00);
    acc(1, 0, PSRC_SLEEP_CONTROL_OFS, 8'hff);
    acc(0, 1, 8'h33, 8'h00);
    check(rd_v, 8'h0f);
    check({7'h0, hit_v}, 8'h01);
    acc(0, 1, 8'h64, 8'h00);
    check({hit_v, rd_v[6:0]}, 8'h00);
    acc(0, 0, 8'h40, 8'h00);
    check({hit_v, rd_v[6:0]}, 8'h00);
    // Every mode code with enable set just before sleeping, then enable clear
    for (int m = 0; m < 8; m++) begin
      acc(1, 0, PSRC_SLEEP_CONTROL_OFS, {4'h0, m[2:0], 1'b1});
      slp();
      check({4'h0, sleep_cmd_o.enter, sleep_cmd_o.mode}, {4'h0, m != 4 && m != 5, m[2:0]});
    end
    acc(1, 0, PSRC_SLEEP_CONTROL_OFS, 8'h04);
    slp();
    check({7'h0, sleep_cmd_o.enter}, 8'h00);
    // Timed brown-out disable, then sleep inside its active window
    acc(1, 0, PSRC_SLEEP_CONTROL_OFS, 8'h05);
    slp();
    check({7'h0, sleep_cmd_o.bod_off}, 8'h00);
    acc(1, 0, PSRC_MCU_CONTROL_OFS, 8'h60);
    acc(1, 0, PSRC_MCU_CONTROL_OFS, 8'h40);
    seen = 1'b0;
    repeat (5) begin
      slp();
      seen = seen | (sleep_cmd_o.enter & sleep_cmd_o.bod_off);
    end
    check({7'h0, seen}, 8'h01);
    acc(0, 0, PSRC_MCU_CONTROL_OFS, 8'h00);
    check(rd_v, 8'h00);
    acc(1, 0, PSRC_MCU_CONTROL_OFS, 8'h10);
    @(negedge clock_i);
    check({7'h0, global_pullup_disable_o}, 8'h01);
    // Vector move with interrupt blocking
    acc(1, 0, PSRC_MCU_CONTROL_OFS, 8'h01);
    check({7'h0, irq_block_o}, 8'h01);
    acc(1, 0, PSRC_MCU_CONTROL_OFS, 8'h02);
    acc(0, 0, PSRC_MCU_CONTROL_OFS, 8'h00);
    check({6'h0, vectors_in_boot_o, global_pullup_disable_o}, 8'h02);
    check(rd_v, 8'h02);
    app_side_boot_lock_i = 1'b1;
    repeat (2) @(negedge clock_i);
    check({7'h0, irq_block_o}, 8'h01);
    exec_in_boot_i = 1'b1;
    repeat (2) @(negedge clock_i);
    check({7'h0, irq_block_o}, 8'h00);
    acc(1, 0, PSRC_MCU_CONTROL_OFS, 8'h01);
    repeat (6) @(negedge clock_i);
    acc(0, 0, PSRC_MCU_CONTROL_OFS, 8'h00);
    check({irq_block_o, rd_v[6:0]}, 8'h02);
    acc(1, 0, PSRC_MCU_CONTROL_OFS, 8'h00);
    check({7'h0, vectors_in_boot_o}, 8'h01);
    // Each source resets ports at once and registers after the stretch
    for (int s = 0; s < 4; s++) begin
      acc(1, 0, PSRC_POWER_REDUCTION_OFS, 8'h01);
      {power_on_rst_i, ext_rst_pin_n_i, brownout_rst_i, watchdog_rst_pulse_i} = 4'b0100 ^ (4'b1000 >> s);
      #1 check({7'h0, port_rst_o}, 8'h01);
      @(negedge clock_i);
      if (s != 3) repeat (2) @(negedge clock_i);
      {power_on_rst_i, ext_rst_pin_n_i, brownout_rst_i, watchdog_rst_pulse_i} = 4'b0100;
      #1 check({6'h0, port_rst_o, core_rst_o}, 8'h01);
      wait_run();
      check(n[7:0], 8'h07);
      acc(0, 0, PSRC_POWER_REDUCTION_OFS, 8'h00);
      check({vectors_in_boot_o, rd_v[6:0]}, 8'h00);
    end
    // Vectors back in the application area, boot-side lock, boot code
    boot_side_boot_lock_i = 1'b1;
    repeat (2) @(negedge clock_i);
    check({7'h0, irq_block_o}, 8'h01);
    close_out();
  end
endmodule : psrc_power_sleep_reset_control_tb
